/* File: core/pmr_pkg.sv */
// Package for the program memory read and write control block.
`default_nettype none
package pmr_pkg;

  // Register port word offsets.
  localparam logic [2:0] PMR_OFF_ADDR_LO = 3'h0;
  localparam logic [2:0] PMR_OFF_ADDR_HI = 3'h1;
  localparam logic [2:0] PMR_OFF_WORD_LO = 3'h2;
  localparam logic [2:0] PMR_OFF_WORD_HI = 3'h3;
  localparam logic [2:0] PMR_OFF_CTRL    = 3'h4;
  localparam logic [2:0] PMR_OFF_UNLOCK  = 3'h5;

  // Control register field positions.
  localparam int PMR_BIT_CAL    = 6;
  localparam int PMR_BIT_PERMIT = 2;
  localparam int PMR_BIT_LAUNCH = 1;
  localparam int PMR_BIT_FETCH  = 0;

  // Field widths and reset values.
  localparam int PMR_ADDR_HI_W = 4;
  localparam int PMR_WORD_HI_W = 6;
  localparam int PMR_ADDR_W    = 12;
  localparam int PMR_WORD_W    = 14;
  localparam logic [7:0] PMR_BYTE_RST = 8'h00;
  localparam logic [7:0] PMR_ZERO     = 8'h00;

  // Unlock sequence keys.
  localparam logic [7:0] PMR_KEY_FIRST  = 8'h55;
  localparam logic [7:0] PMR_KEY_SECOND = 8'hAA;

  // Read sequencer: trigger cycle, skipped slot, array access.
  typedef enum logic [1:0] {
    PMR_IDLE   = 2'b00,
    PMR_SKIP   = 2'b01,
    PMR_ACCESS = 2'b10
  } pmr_state_t;

  // Unlock tracker.
  typedef enum logic [1:0] {
    PMR_LOCKED = 2'b00,
    PMR_HALF   = 2'b01,
    PMR_ARMED  = 2'b10
  } pmr_lock_t;

  // Request toward the flash array.
  typedef struct packed {
    logic                  rd;
    logic                  wr_start;
    logic                  cal;
    logic [PMR_ADDR_W-1:0] addr;
    logic [PMR_WORD_W-1:0] wdata;
  } pmr_flash_req_t;

endpackage : pmr_pkg
`default_nettype wire

/* File: core/pmr_ctrl.sv */
// Program memory read and write control logic with its register file.
// Notes on behaviour
// - Calibration select steers reads to test area
// - Writes allowed only while program permit set
// - Launch bit starts write, hardware clears
// - Fetch trigger starts one-cycle read, set-only
// - Unused control bits ignore writes, read zero
// - High nibble gives top four address bits
// - Array access in second cycle after trigger
// - Second instruction after trigger is discarded
// - Fetched word visible the next cycle
// - Word registers hold until read or write
// - No write while calibration select set
// - Unlock keys must precede write launch
// - Unlock port stores nothing, reads zero
//
// Decided for this implementation: strobed register access and the address map.
`default_nettype none
module pmr_ctrl
  import pmr_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clock,
  input  wire logic                  reset,
  // Register port.
  input  wire logic [2:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // Flash array side.
  output pmr_flash_req_t             flash_req,
  input  wire logic [PMR_WORD_W-1:0] flash_rdata,
  input  wire logic                  flash_write_done,
  // Core pipeline side.
  output logic                       discard_instr
);

  // Register state.
  logic [7:0]               addr_lo_ff;
  logic [7:0]               nxt_addr_lo;
  logic [PMR_ADDR_HI_W-1:0] addr_hi_ff;
  logic [PMR_ADDR_HI_W-1:0] nxt_addr_hi;
  logic [7:0]               word_lo_ff;
  logic [7:0]               nxt_word_lo;
  logic [PMR_WORD_HI_W-1:0] word_hi_ff;
  logic [PMR_WORD_HI_W-1:0] nxt_word_hi;
  logic                     cal_ff;
  logic                     nxt_cal;
  logic                     permit_ff;
  logic                     nxt_permit;
  logic                     launch_ff;
  logic                     nxt_launch;
  logic                     wr_start_ff;
  logic                     nxt_wr_start;
  pmr_state_t               state_ff;
  pmr_state_t               nxt_state;
  pmr_lock_t                lock_ff;
  pmr_lock_t                nxt_lock;
  logic [7:0]               rdata_ff;
  logic [7:0]               nxt_rdata;

  // Decoded strobes.
  logic wr_ctrl;
  logic wr_unlock;
  logic fetch_bit;
  logic fetch_set;
  logic launch_try;
  logic launch_ok;
  logic access;

  // Control register view; unused positions stay zero.
  logic [7:0] ctrl_view;

  // Strobe decode and the write acceptance check.
  always_comb begin
    wr_ctrl    = reg_wr && (reg_addr == PMR_OFF_CTRL);
    wr_unlock  = reg_wr && (reg_addr == PMR_OFF_UNLOCK);
    fetch_bit  = (state_ff != PMR_IDLE);
    access     = (state_ff == PMR_ACCESS);
    // A new trigger is taken when idle, or in the access cycle where
    // the set beats the hardware clear and restarts the sequence.
    fetch_set  = wr_ctrl && reg_wdata[PMR_BIT_FETCH]
                 && (!fetch_bit || access);
    launch_try = wr_ctrl && reg_wdata[PMR_BIT_LAUNCH] && !launch_ff;
    // Permit, unlock and user space are all needed; permit and select
    // are taken from the same write so one instruction can set both.
    launch_ok  = launch_try
                 && reg_wdata[PMR_BIT_PERMIT]
                 && !reg_wdata[PMR_BIT_CAL]
                 && (lock_ff == PMR_ARMED);
  end

  // Control view for reads.
  always_comb begin
    ctrl_view                 = PMR_ZERO;
    ctrl_view[PMR_BIT_CAL]    = cal_ff;
    ctrl_view[PMR_BIT_PERMIT] = permit_ff;
    ctrl_view[PMR_BIT_LAUNCH] = launch_ff;
    ctrl_view[PMR_BIT_FETCH]  = fetch_bit;
  end

  // Address registers; only the low nibble of the high byte is kept.
  always_comb begin
    nxt_addr_lo = addr_lo_ff;
    nxt_addr_hi = addr_hi_ff;
    if (reg_wr && reg_addr == PMR_OFF_ADDR_LO) begin
      nxt_addr_lo = reg_wdata;
    end
    if (reg_wr && reg_addr == PMR_OFF_ADDR_HI) begin
      nxt_addr_hi = reg_wdata[PMR_ADDR_HI_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      addr_lo_ff <= PMR_BYTE_RST;
      addr_hi_ff <= PMR_BYTE_RST[PMR_ADDR_HI_W-1:0];
    end else begin
      addr_lo_ff <= nxt_addr_lo;
      addr_hi_ff <= nxt_addr_hi;
    end
  end

  // Word registers; the array capture wins over a software write in the
  // same cycle, since the fetched word is what the program waits for.
  always_comb begin
    nxt_word_lo = word_lo_ff;
    nxt_word_hi = word_hi_ff;
    if (reg_wr && reg_addr == PMR_OFF_WORD_LO) begin
      nxt_word_lo = reg_wdata;
    end
    if (reg_wr && reg_addr == PMR_OFF_WORD_HI) begin
      nxt_word_hi = reg_wdata[PMR_WORD_HI_W-1:0];
    end
    if (access) begin
      nxt_word_lo = flash_rdata[7:0];
      nxt_word_hi = flash_rdata[PMR_WORD_W-1:8];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      word_lo_ff <= PMR_BYTE_RST;
      word_hi_ff <= PMR_BYTE_RST[PMR_WORD_HI_W-1:0];
    end else begin
      word_lo_ff <= nxt_word_lo;
      word_hi_ff <= nxt_word_hi;
    end
  end

  // Control bits; zero writes to launch never clear it.
  always_comb begin
    nxt_cal      = cal_ff;
    nxt_permit   = permit_ff;
    nxt_launch   = launch_ff;
    nxt_wr_start = launch_ok;
    if (wr_ctrl) begin
      nxt_cal    = reg_wdata[PMR_BIT_CAL];
      nxt_permit = reg_wdata[PMR_BIT_PERMIT];
    end
    if (launch_ff && flash_write_done) begin
      nxt_launch = 1'b0;
    end
    if (launch_ok) begin
      nxt_launch = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cal_ff      <= 1'b0;
      permit_ff   <= 1'b0;
      launch_ff   <= 1'b0;
      wr_start_ff <= 1'b0;
    end else begin
      cal_ff      <= nxt_cal;
      permit_ff   <= nxt_permit;
      launch_ff   <= nxt_launch;
      wr_start_ff <= nxt_wr_start;
    end
  end

  // Read sequencer: the slot after the trigger runs normally, the one
  // after that is borrowed for the array and its instruction dropped.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PMR_IDLE: begin
        if (fetch_set) begin
          nxt_state = PMR_SKIP;
        end
      end
      PMR_SKIP: begin
        nxt_state = PMR_ACCESS;
      end
      PMR_ACCESS: begin
        nxt_state = fetch_set ? PMR_SKIP : PMR_IDLE;
      end
      default: begin
        nxt_state = PMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_ff <= PMR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Unlock tracker; the port keeps no data, only sequence progress,
  // and any other write in between breaks the sequence.
  always_comb begin
    nxt_lock = lock_ff;
    if (wr_unlock) begin
      if (reg_wdata == PMR_KEY_FIRST) begin
        nxt_lock = PMR_HALF;
      end else if (reg_wdata == PMR_KEY_SECOND && lock_ff == PMR_HALF) begin
        nxt_lock = PMR_ARMED;
      end else begin
        nxt_lock = PMR_LOCKED;
      end
    end else if (reg_wr) begin
      nxt_lock = PMR_LOCKED;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lock_ff <= PMR_LOCKED;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  // Read data register; unmapped offsets and the unlock port read zero.
  always_comb begin
    nxt_rdata = PMR_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        PMR_OFF_ADDR_LO: nxt_rdata = addr_lo_ff;
        PMR_OFF_ADDR_HI: nxt_rdata = {4'h0, addr_hi_ff};
        PMR_OFF_WORD_LO: nxt_rdata = word_lo_ff;
        PMR_OFF_WORD_HI: nxt_rdata = {2'h0, word_hi_ff};
        PMR_OFF_CTRL:    nxt_rdata = ctrl_view;
        PMR_OFF_UNLOCK:  nxt_rdata = PMR_ZERO;
        default:         nxt_rdata = PMR_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_ff <= PMR_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs toward the array and the pipeline.
  always_comb begin
    reg_rdata          = rdata_ff;
    flash_req.rd       = access;
    flash_req.wr_start = wr_start_ff;
    flash_req.cal      = cal_ff;
    flash_req.addr     = {addr_hi_ff, addr_lo_ff};
    flash_req.wdata    = {word_hi_ff, word_lo_ff};
    discard_instr      = access;
  end

  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // A trigger taken in the access cycle is legal, so only the two slots
  // after the trigger are looked at, never the trigger cycle itself.
  AST_READ_TWO_LATER: assert property (
    fetch_set |=> !flash_req.rd ##1 flash_req.rd)
    else $error("array read not in second cycle after trigger");
  AST_DISCARD_SLOT: assert property (
    fetch_set |=> !discard_instr ##1 discard_instr)
    else $error("wrong instruction slot discarded");
  AST_WORD_NEXT: assert property (
    flash_req.rd |=> {word_hi_ff, word_lo_ff} == $past(flash_rdata))
    else $error("fetched word not shown next cycle");
  AST_WORD_HOLD: assert property (
    !flash_req.rd && !(reg_wr && (reg_addr == PMR_OFF_WORD_LO
      || reg_addr == PMR_OFF_WORD_HI)) |=> $stable(flash_req.wdata))
    else $error("word registers changed without cause");
  AST_FETCH_CLEARS: assert property (
    (flash_req.rd && !fetch_set) |=> !ctrl_view[PMR_BIT_FETCH])
    else $error("fetch bit not cleared after access");
  AST_NO_WRITE_LOCKED: assert property (
    $rose(launch_ff) |-> $past(lock_ff) == PMR_ARMED)
    else $error("write launched without unlock sequence");
  AST_NO_WRITE_DENIED: assert property (
    $rose(launch_ff) |-> permit_ff && !cal_ff)
    else $error("write launched without permit or in test space");
  AST_LAUNCH_STICKS: assert property (
    launch_ff && !flash_write_done |=> launch_ff)
    else $error("launch bit cleared before write done");
  AST_START_PULSE: assert property (
    $rose(launch_ff) |-> flash_req.wr_start ##1 !flash_req.wr_start)
    else $error("write start pulse missing or long");
  AST_UNUSED_ZERO: assert property (
    reg_rd && reg_addr == PMR_OFF_CTRL |=> reg_rdata[7] == 1'b0
      && reg_rdata[5:3] == 3'h0)
    else $error("unused control bits read nonzero");
  AST_UNLOCK_ZERO: assert property (
    reg_rd && reg_addr == PMR_OFF_UNLOCK |=> reg_rdata == PMR_ZERO)
    else $error("unlock port read nonzero");
  AST_ADDR_SRC: assert property (
    reg_wr && reg_addr == PMR_OFF_ADDR_HI
      |=> flash_req.addr[PMR_ADDR_W-1:8] == $past(reg_wdata[3:0]))
    else $error("high nibble not driving address");

  COV_READ: cover property (fetch_set ##2 flash_req.rd ##1 reg_rd);
  COV_BACK_TO_BACK: cover property (flash_req.rd && fetch_set);
  COV_WRITE: cover property ($rose(launch_ff) ##[1:20] !launch_ff);
  COV_CAL_READ: cover property (flash_req.rd && flash_req.cal);

endmodule : pmr_ctrl
`default_nettype wire

/* File: bench/pmr_ctrl_tb.sv */
// Self-checking bench for the program memory control block.
`default_nettype none
module pmr_ctrl_tb
  import pmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clock = 1'b0;
  logic                  reset = 1'b1;
  logic [2:0]            reg_addr = 3'h0;
  logic [7:0]            reg_wdata = 8'h00;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [7:0]            reg_rdata;
  pmr_flash_req_t        req;
  logic [PMR_WORD_W-1:0] flash_rdata = 14'h0000;
  logic                  flash_write_done = 1'b0;
  logic                  discard_instr;
  logic                  rd_d = 1'b0;
  logic [7:0]            exp_q[$];
  logic [7:0]            exp_b;
  int                    n_errors = 0;
  int                    samples_checked = 0;
  int                    cycles = 0;

  // Free-running instruction clock, 25 ns period.
  always #12.5 clock = ~clock;

  pmr_ctrl i_dut (
    .clock            (clock),
    .reset            (reset),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .flash_req        (req),
    .flash_rdata      (flash_rdata),
    .flash_write_done (flash_write_done),
    .discard_instr    (discard_instr)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Compares one value; case inequality so an unknown never matches.
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One write cycle; the strobe is left up so back-to-back calls work.
  task automatic wr(logic [2:0] a, logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge clock);
  endtask : wr

  // One read cycle; the expected byte is queued for the monitor.
  task automatic rd(logic [2:0] a, logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    @(posedge clock);
  endtask : rd

  // Drops both strobes and lets n edges pass.
  task automatic idle(int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : idle

  // Read data stand only in the cycle after the strobe, so look there.
  always @(posedge clock) rd_d <= reg_rd && !reset;
  always @(negedge clock) begin
    if (rd_d) begin
      exp_b = exp_q.pop_front();
      chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp_b});
    end
  end

  // A hang counts as a failure and still reaches the verdict.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    logic [11:0] a;
    logic [13:0] w;
    logic        c;
    logic [7:0]  inh_d[3];
    logic [7:0]  inh_e[3];
    inh_d = '{8'h06, 8'h46, 8'h02};
    inh_e = '{8'h04, 8'h44, 8'h00};
    void'($urandom(32'h718e_ac1e));
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    // Every offset, mapped or not, reads zero out of reset.
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
    $display("reset test done");
    // Unused bits must be dropped; the unlock port keeps nothing.
    wr(1, 8'hFF);
    wr(3, 8'hFF);
    wr(4, 8'hFC);
    wr(5, 8'h55);
    wr(6, 8'hFF);
    rd(1, 8'h0F);
    rd(3, 8'h3F);
    rd(4, 8'h44);
    rd(5, 8'h00);
    rd(6, 8'h00);
    wr(4, 8'h00);
    $display("register test done");
    // Random reads: the array slot is the second cycle after trigger.
    // Odd passes read the calibration area so both spaces are seen.
    for (int j = 0; j < 4; j++) begin
      a = 12'($urandom());
      w = 14'($urandom());
      c = j[0];
      flash_rdata <= w;
      wr(0, a[7:0]);
      wr(1, {w[3:0], a[11:8]});
      wr(4, {1'b0, c, 6'h01});
      idle(0);
      @(negedge clock);
      chk("rd early", {15'h0, req.rd}, 16'h0000);
      chk("discard early", {15'h0, discard_instr}, 16'h0000);
      @(negedge clock);
      chk("rd slot", {15'h0, req.rd}, 16'h0001);
      chk("discard", {15'h0, discard_instr}, 16'h0001);
      chk("addr", {4'h0, req.addr}, {4'h0, a});
      chk("cal", {15'h0, req.cal}, {15'h0, c});
      @(posedge clock);
      // Changing the array word proves the capture edge.
      flash_rdata <= ~w;
      rd(2, w[7:0]);
      rd(3, {2'b00, w[13:8]});
      rd(4, {1'b0, c, 6'h00});
      idle(3);
      rd(2, w[7:0]);
    end
    wr(4, 8'h00);
    // A trigger in the access slot restarts the read at once.
    wr(4, 8'h01);
    idle(1);
    wr(4, 8'h01);
    idle(0);
    @(negedge clock);
    chk("restart", {15'h0, req.rd}, 16'h0000);
    @(negedge clock);
    chk("restart slot", {15'h0, req.rd}, 16'h0001);
    @(posedge clock);
    rd(2, ~w[7:0]);
    rd(4, 8'h00);
    $display("read test done");
    // Unlocked write: pulse, launch held, software zero ignored.
    wr(2, w[7:0]);
    wr(3, {2'b00, w[13:8]});
    wr(5, PMR_KEY_FIRST);
    wr(5, PMR_KEY_SECOND);
    wr(4, 8'h06);
    idle(0);
    @(negedge clock);
    chk("wr_start", {15'h0, req.wr_start}, 16'h0001);
    chk("wdata", {2'h0, req.wdata}, {2'h0, w});
    @(posedge clock);
    wr(4, 8'h00);
    rd(4, 8'h02);
    flash_write_done <= 1'b1;
    idle(1);
    flash_write_done <= 1'b0;
    rd(4, 8'h00);
    $display("write test done");
    // No keys, calibration select, or no permit: no write starts.
    for (int k = 0; k < 3; k++) begin
      if (k > 0) begin
        wr(5, PMR_KEY_FIRST);
        wr(5, PMR_KEY_SECOND);
      end
      wr(4, inh_d[k]);
      idle(0);
      @(negedge clock);
      chk("no wr", {15'h0, req.wr_start}, 16'h0000);
      @(posedge clock);
      rd(4, inh_e[k]);
      wr(4, 8'h00);
    end
    idle(3);
    $display("inhibit test done");
    report_and_stop();
  end
endmodule : pmr_ctrl_tb
`default_nettype wire
